// File: logic/bpm_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module bpm_ctrl
   import bpm_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Analog comparator results
   input wire bpm_cmp_t cmp,
   // Supervisor internal requests
   input wire logic reset_req,
   input wire logic pf_req,
   input wire logic piezo_req,
   input wire logic alarm_req,
   input wire logic crystal_fault_req,
   // Host-facing inputs
   input wire logic manual_reset_in,
   input wire logic watchdog_kick_in,
   input wire logic chip_select_in,
   input wire logic twi_active_in,
   // Gated inputs to the rest of the device
   output logic manual_reset_gated,
   output logic watchdog_kick_gated,
   output logic chip_select_gated,
   output logic twi_enable,
   // Outputs to pins
   output logic reset_out_n,
   output logic reset_out,
   output logic power_fail_flag_out,
   output logic piezo_drive_o,
   output logic piezo_drive_oe,
   output logic chip_select_out,
   output logic alarm_out_n,
   output logic crystal_fault_out,
   output logic on_backup_indicator,
   // Supply switch controls
   output logic out_from_primary,
   output logic out_from_backup,
   output bpm_chg_t charger,
   output logic timekeeping_run,
   output logic regs_released
);

   // Decode of the trickle register into a charger selection
   function automatic bpm_chg_t bpm_decode(input logic [7:0] val);
      bpm_chg_t c;
      logic [3:0] key;
      logic [1:0] dio;
      logic [1:0] res;
      key = val[BPM_KEY_LSB +: 4];
      dio = val[BPM_DIODE_LSB +: 2];
      res = val[BPM_RES_LSB +: 2];
      c.two_diodes = (dio == BPM_DIODE_TWO);
      c.resistor = res;
      c.enable = (key == BPM_UNLOCK_KEY) &&
         ((dio == BPM_DIODE_NONE) || (dio == BPM_DIODE_TWO)) &&
         (res != BPM_RES_OFF);
      return c;
   endfunction : bpm_decode

   logic [7:0] trickle_charge_control; // Software charger setting
   logic [1:0] feature_en; // Alarm and crystal-fault enables
   logic sealed; // Fresh-seal state
   bpm_src_t src; // Active supply source
   bpm_src_t next_src;
   logic on_backup; // Running from backup
   logic reset_active; // Either reset output asserted
   logic rd_pending; // Read answered one cycle later
   logic wr_hit; // Write accepted this cycle
   logic [31:0] status_word; // Block state for software
   logic prev_por; // Release comparator one cycle ago
   logic prev_keep; // Retention comparator one cycle ago

   assign on_backup = (src == BPM_SRC_BACKUP);
   assign reset_active = !reset_out_n || reset_out;
   assign wr_hit = avs_write && !avs_waitrequest;

   // Source decision from comparators
   always_comb begin
      if (sealed) begin
         next_src = BPM_SRC_NONE;
      end else if (cmp.above_reset || cmp.above_trip) begin
         next_src = BPM_SRC_PRIMARY;
      end else begin
         next_src = BPM_SRC_BACKUP;
      end
   end

   // Seal held until the primary first crosses the threshold
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         sealed <= 1'b1;
      end else if (cmp.above_reset) begin
         sealed <= 1'b0;
      end
   end

   // Active source register
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         src <= BPM_SRC_NONE;
      end else begin
         src <= next_src;
      end
   end

   // Switch: both open for one cycle between sources
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         out_from_primary <= 1'b0;
         out_from_backup <= 1'b0;
      end else if (sealed) begin
         out_from_primary <= 1'b0;
         out_from_backup <= 1'b0;
      end else if (cmp.above_reset || cmp.above_backup) begin
         out_from_backup <= 1'b0;
         out_from_primary <= !out_from_backup;
      end else begin
         out_from_primary <= 1'b0;
         out_from_backup <= !out_from_primary;
      end
   end

   // Edge memory of the switched-supply comparators
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         prev_por <= 1'b0; // Supply taken as down in reset
         prev_keep <= 1'b0;
      end else begin
         prev_por <= cmp.out_above_por;
         prev_keep <= cmp.out_above_keep;
      end
   end

   // Release on a rise past the release level, drop on a dip below retention;
   // edges only, so a supply parked between the two levels cannot oscillate
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         regs_released <= 1'b0;
      end else if (cmp.out_above_por && !prev_por) begin
         regs_released <= 1'b1; // set wins
      end else if (prev_keep && !cmp.out_above_keep) begin
         regs_released <= 1'b0;
      end
   end

   // Reset and power-fail outputs, forced on backup or seal
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         reset_out_n <= 1'b0;
         reset_out <= 1'b1;
         power_fail_flag_out <= 1'b0;
      end else if (on_backup || sealed) begin
         reset_out_n <= 1'b0;
         reset_out <= 1'b1;
         power_fail_flag_out <= 1'b0;
      end else begin
         reset_out_n <= !reset_req;
         reset_out <= reset_req;
         power_fail_flag_out <= !pf_req;
      end
   end

   // Piezo and chip-select outputs
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         piezo_drive_o <= 1'b0;
         piezo_drive_oe <= 1'b0;
         chip_select_out <= 1'b1;
      end else if (on_backup || sealed) begin
         piezo_drive_o <= 1'b0;
         piezo_drive_oe <= 1'b0;
         chip_select_out <= 1'b1;
      end else begin
         piezo_drive_o <= piezo_req;
         piezo_drive_oe <= 1'b1;
         chip_select_out <= chip_select_gated;
      end
   end

   // Host input gating while reset is asserted
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         manual_reset_gated <= 1'b1;
         watchdog_kick_gated <= 1'b0;
         chip_select_gated <= 1'b1;
         twi_enable <= 1'b0;
      end else if (reset_active || on_backup || sealed) begin
         manual_reset_gated <= 1'b1;
         watchdog_kick_gated <= 1'b0;
         chip_select_gated <= 1'b1;
         twi_enable <= 1'b0;
      end else begin
         manual_reset_gated <= manual_reset_in;
         watchdog_kick_gated <= watchdog_kick_in;
         chip_select_gated <= chip_select_in;
         twi_enable <= twi_active_in;
      end
   end

   // Functions kept alive on backup
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         timekeeping_run <= 1'b0;
         alarm_out_n <= 1'b1;
         crystal_fault_out <= 1'b0;
         on_backup_indicator <= 1'b0;
      end else begin
         timekeeping_run <= !sealed;
         alarm_out_n <= !(feature_en[0] && alarm_req && !sealed);
         crystal_fault_out <= feature_en[1] && crystal_fault_req && !sealed;
         on_backup_indicator <= on_backup;
      end
   end

   // Charger: decoded setting, forced off below backup supply
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         charger <= '0;
      end else begin
         charger <= bpm_decode(trickle_charge_control);
         if (!cmp.above_backup || on_backup || sealed) begin
            charger.enable <= 1'b0;
         end
      end
   end

   // Register writes, low byte lane only
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         trickle_charge_control <= BPM_TRICKLE_RST;
         feature_en <= BPM_FEATURE_RST;
      end else if (wr_hit && avs_byteenable[0]) begin
         if (avs_address == BPM_TRICKLE_OFS) begin
            trickle_charge_control <= avs_writedata[7:0];
         end
         if (avs_address == BPM_FEATURE_OFS) begin
            feature_en <= avs_writedata[1:0];
         end
      end
   end

   // Status word of block state
   always_comb begin
      status_word = '0;
      status_word[BPM_ST_BACKUP] = on_backup;
      status_word[BPM_ST_SEALED] = sealed;
      status_word[BPM_ST_CHARGE] = charger.enable;
      status_word[BPM_ST_RESET] = reset_active;
      status_word[BPM_ST_REGOK] = regs_released;
   end

   // Bus handshake: writes in one cycle, reads after one wait
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rd_pending <= 1'b0;
         avs_readdata <= '0;
      end else begin
         rd_pending <= avs_read && !rd_pending;
         if (avs_read && !rd_pending) begin
            unique case (avs_address)
               BPM_TRICKLE_OFS: avs_readdata <= {24'h0, trickle_charge_control};
               BPM_STATUS_OFS: avs_readdata <= status_word;
               BPM_FEATURE_OFS: avs_readdata <= {30'h0, feature_en};
               default: avs_readdata <= 32'h0; // Unmapped reads zero
            endcase
         end
      end
   end

   // Waitrequest low for writes, low on second read cycle
   always_comb begin
      avs_waitrequest = avs_read && !rd_pending;
   end

   // Charger never enabled with primary below backup
   chg_off_low_a: assert property (@(posedge core_clk) disable iff (!resetn)
      !cmp.above_backup |=> !charger.enable)
      else $error("charger on below backup");
   // Wrong key keeps charger off
   key_lock_a: assert property (@(posedge core_clk) disable iff (!resetn)
      $stable(trickle_charge_control) && trickle_charge_control[7:4] != BPM_UNLOCK_KEY
      |=> !charger.enable)
      else $error("charger on without key");
   // Invalid diode code disables
   diode_code_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (trickle_charge_control[3:2] == 2'h0 || trickle_charge_control[3:2] == 2'h3)
      |=> !charger.enable)
      else $error("charger on with bad diode code");
   // Resistor zero disables
   res_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
      trickle_charge_control[1:0] == 2'h0 |=> !charger.enable)
      else $error("charger on with no resistor");
   // Backup forces reset outputs and flag
   backup_force_a: assert property (@(posedge core_clk) disable iff (!resetn)
      on_backup |=> !reset_out_n && reset_out && !power_fail_flag_out
      && !piezo_drive_oe && chip_select_out)
      else $error("outputs not forced on backup");
   // Gated inputs held while reset asserted
   input_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
      reset_active |=> !twi_enable && manual_reset_gated && chip_select_gated)
      else $error("inputs not gated during reset");
   // Source choice from comparators
   src_choice_a: assert property (@(posedge core_clk) disable iff (!resetn)
      !sealed && !cmp.above_reset && !cmp.above_trip |=> src == BPM_SRC_BACKUP)
      else $error("backup not selected");
   // Seal persists without primary above threshold
   seal_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
      sealed && !cmp.above_reset |=> sealed && !timekeeping_run)
      else $error("seal left early");
   // Never both sources connected
   break_make_a: assert property (@(posedge core_clk) disable iff (!resetn)
      !(out_from_primary && out_from_backup))
      else $error("both sources connected");
   // Charger off after reset
   por_off_a: assert property (@(posedge core_clk)
      !resetn |=> !charger.enable && trickle_charge_control == BPM_TRICKLE_RST)
      else $error("charger not off after reset");
   // Timekeeping runs on backup
   keep_time_a: assert property (@(posedge core_clk) disable iff (!resetn)
      on_backup && !sealed |=> timekeeping_run)
      else $error("timekeeping stopped on backup");
   // Release lost below retention level
   por_drop_a: assert property (@(posedge core_clk) disable iff (!resetn)
      prev_keep && !cmp.out_above_keep && !(cmp.out_above_por && !prev_por)
      |=> !regs_released)
      else $error("release kept after dip");
   // Release granted on a rise past the release level
   por_rise_a: assert property (@(posedge core_clk) disable iff (!resetn)
      cmp.out_above_por && !prev_por |=> regs_released)
      else $error("release not granted");

endmodule : bpm_ctrl
`default_nettype wire

// File: shared/bpm_pkg.sv
`default_nettype none
package bpm_pkg;
   // Register word offsets (byte addresses)
   localparam logic [3:0] BPM_TRICKLE_OFS = 4'h0;
   localparam logic [3:0] BPM_STATUS_OFS = 4'h4;
   localparam logic [3:0] BPM_FEATURE_OFS = 4'h8;
   // Trickle register reset value: charger disabled
   localparam logic [7:0] BPM_TRICKLE_RST = 8'h00;
   // Feature enable reset value
   localparam logic [1:0] BPM_FEATURE_RST = 2'h0;
   // Trickle field positions
   localparam int BPM_KEY_LSB = 4;
   localparam int BPM_DIODE_LSB = 2;
   localparam int BPM_RES_LSB = 0;
   // Unlock key and field codes
   localparam logic [3:0] BPM_UNLOCK_KEY = 4'ha;
   localparam logic [1:0] BPM_DIODE_NONE = 2'h2;
   localparam logic [1:0] BPM_DIODE_TWO = 2'h1;
   localparam logic [1:0] BPM_RES_1K7 = 2'h2;
   localparam logic [1:0] BPM_RES_2K9 = 2'h1;
   localparam logic [1:0] BPM_RES_5K = 2'h3;
   localparam logic [1:0] BPM_RES_OFF = 2'h0;
   // Status bit positions
   localparam int BPM_ST_BACKUP = 0;
   localparam int BPM_ST_SEALED = 1;
   localparam int BPM_ST_CHARGE = 2;
   localparam int BPM_ST_RESET = 3;
   localparam int BPM_ST_REGOK = 4;
   // Supply source selection
   typedef enum logic [1:0] {
      BPM_SRC_NONE = 2'b00,
      BPM_SRC_PRIMARY = 2'b01,
      BPM_SRC_BACKUP = 2'b10
   } bpm_src_t;
   // Comparator results from the analog side
   typedef struct packed {
      logic above_reset;     // Primary above reset threshold
      logic above_trip;      // Primary above battery trip level
      logic above_backup;    // Primary above backup supply
      logic out_above_por;   // Switched supply above release level
      logic out_above_keep;  // Switched supply above retention level
   } bpm_cmp_t;
   // Decoded charger selection
   typedef struct packed {
      logic enable;
      logic two_diodes;
      logic [1:0] resistor;
   } bpm_chg_t;
endpackage : bpm_pkg
`default_nettype wire

// File: verif/bpm_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host side: reset button, watchdog kick, chip select and bus activity
module bpm_host_model (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [3:0] pattern,
   output logic manual_reset_in,
   output logic watchdog_kick_in,
   output logic chip_select_in,
   output logic twi_active_in
);
   // Idle levels in reset, else the commanded pattern, changed after an edge
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         {manual_reset_in, watchdog_kick_in, chip_select_in, twi_active_in} <= 4'ha;
      end else begin
         {manual_reset_in, watchdog_kick_in, chip_select_in, twi_active_in} <= pattern;
      end
   end
endmodule : bpm_host_model
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import bpm_pkg::*;
   logic core_clk = 1'b0; // 250 MHz
   logic resetn = 1'b0; // Sync, active low
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   bpm_cmp_t cmp = 5'h00; // Comparator levels
   logic [4:0] req = 5'h00; // Reset, pf, piezo, alarm, crystal requests
   logic [3:0] pattern = 4'ha; // Host lines: mr, wdi, cs, twi
   wire logic [3:0] host; // Raw host lines
   wire logic [3:0] gated; // Gated host lines
   logic [31:0] rd; // Last read data
   logic rst_n, rst_h, pf_n, pz_o, pz_oe, cs_out, alarm_n, xfail, on_backup_supply;
   logic from_pri, from_bat, tk_run, released;
   bpm_chg_t charger;
   logic en; // Expected charger enable
   logic [7:0] codes [12] = '{8'ha0, 8'hae, 8'ha8, 8'h5a, 8'hba, 8'h2a,
      8'ha9, 8'hab, 8'ha6, 8'ha5, 8'ha7, 8'haa}; // Trickle settings
   int errors = 0;
   int compares = 0;

   // Clock
   always #2 core_clk = ~core_clk;

   bpm_host_model host_m (.core_clk(core_clk), .resetn(resetn), .pattern(pattern),
      .manual_reset_in(host[3]), .watchdog_kick_in(host[2]),
      .chip_select_in(host[1]), .twi_active_in(host[0]));

   bpm_ctrl DUT (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cmp(cmp), .reset_req(req[4]),
      .pf_req(req[3]), .piezo_req(req[2]), .alarm_req(req[1]),
      .crystal_fault_req(req[0]), .manual_reset_in(host[3]),
      .watchdog_kick_in(host[2]), .chip_select_in(host[1]), .twi_active_in(host[0]),
      .manual_reset_gated(gated[3]), .watchdog_kick_gated(gated[2]),
      .chip_select_gated(gated[1]), .twi_enable(gated[0]), .reset_out_n(rst_n),
      .reset_out(rst_h), .power_fail_flag_out(pf_n), .piezo_drive_o(pz_o),
      .piezo_drive_oe(pz_oe), .chip_select_out(cs_out), .alarm_out_n(alarm_n),
      .crystal_fault_out(xfail), .on_backup_indicator(on_backup_supply),
      .out_from_primary(from_pri), .out_from_backup(from_bat), .charger(charger),
      .timekeeping_run(tk_run), .regs_released(released));

   // Compare and count
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Verdict and end of run
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up

   // Hold request until waitrequest is sampled low at a rising edge, bounded
   task automatic wait_ack;
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 64);
      if (avs_waitrequest !== 1'b0) begin
         errors++;
         wrap_up();
      end
      rd = avs_readdata; // Taken at the edge that ends the transfer
   endtask : wait_ack

   // Bus write of one byte
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      avs_write <= 1'b1;
      wait_ack();
      avs_write <= 1'b0;
   endtask : bus_wr

   // Bus read into rd
   task automatic bus_rd(input logic [3:0] a);
      @(posedge core_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      wait_ack();
      avs_read <= 1'b0;
   endtask : bus_rd

   // New supply levels and requests, then let the flops settle
   task automatic settle(input bpm_cmp_t c, input logic [4:0] r);
      @(posedge core_clk);
      cmp <= c;
      req <= r;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
   endtask : settle

   // Hang guard
   initial begin
      #100000;
      errors++;
      wrap_up();
   end

   // Main sequence
   initial begin
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      // Sealed: primary never above threshold yet
      settle(5'h03, 5'h00);
      chk("released", released, 1'h1);
      chk("reset sealed", rst_n, 1'h0);
      bus_rd(BPM_TRICKLE_OFS);
      chk("trickle por", rd, BPM_TRICKLE_RST);
      bus_wr(BPM_TRICKLE_OFS, 8'haa, 4'h1);
      settle(5'h03, 5'h00);
      chk("charge sealed", charger.enable, 1'h0);
      bus_rd(BPM_STATUS_OFS);
      chk("sealed bit", rd[BPM_ST_SEALED], 1'h1);
      chk("status sealed", rd[BPM_ST_REGOK:BPM_ST_RESET], 2'h3);
      // Primary applied
      @(posedge core_clk);
      pattern <= 4'h5;
      settle(5'h1f, 5'h0c);
      bus_rd(BPM_STATUS_OFS);
      chk("status primary", rd[1:0], 2'h0);
      chk("switch primary", {from_pri, from_bat}, 2'h2);
      chk("gated pass", gated, 4'h5);
      chk("primary pins", {rst_n, pf_n, pz_o, pz_oe, cs_out}, 5'h16);
      chk("time runs", tk_run, 1'h1);
      settle(5'h1f, 5'h10);
      chk("reset req", {rst_n, rst_h}, 2'h1);
      chk("gated held", gated, 4'ha);
      // Every diode, resistor and key class
      foreach (codes[i]) begin
         bus_wr(BPM_TRICKLE_OFS, codes[i], 4'h1);
         settle(5'h1f, 5'h00);
         en = codes[i][7:4] == BPM_UNLOCK_KEY && codes[i][1:0] != BPM_RES_OFF
            && (codes[i][3:2] == BPM_DIODE_NONE || codes[i][3:2] == BPM_DIODE_TWO);
         chk("charge en", charger.enable, en);
         if (en) begin
            chk("charge sel", {charger.two_diodes, charger.resistor},
               {codes[i][3:2] == BPM_DIODE_TWO, codes[i][1:0]});
         end
         bus_rd(BPM_TRICKLE_OFS);
         chk("trickle rd", rd, codes[i]);
      end
      bus_wr(BPM_TRICKLE_OFS, 8'h00, 4'h0);
      bus_rd(BPM_TRICKLE_OFS);
      chk("no lane write", rd, 8'haa);
      bus_rd(4'hc);
      chk("unmapped", rd, 32'h0);
      // Primary below backup
      settle(5'h1b, 5'h00);
      chk("charge low", charger.enable, 1'h0);
      bus_rd(BPM_STATUS_OFS);
      chk("charge bit", rd[BPM_ST_CHARGE], 1'h0);
      // Below threshold but above trip level
      settle(5'h0f, 5'h00);
      chk("brownout", {on_backup_supply, from_pri, from_bat}, 3'h2);
      // Backup with alarm and crystal fault enabled
      bus_wr(BPM_FEATURE_OFS, 8'h03, 4'h1);
      bus_rd(BPM_FEATURE_OFS);
      chk("feature", rd, 32'h3);
      settle(5'h03, 5'h07);
      chk("on backup", on_backup_supply, 1'h1);
      chk("backup resets", {rst_n, rst_h, pf_n}, 3'h2);
      chk("backup pins", {pz_o, pz_oe, cs_out}, 3'h1);
      chk("switch backup", {from_pri, from_bat}, 2'h1);
      chk("backup keep", {tk_run, alarm_n, xfail}, 3'h5);
      chk("charge backup", charger.enable, 1'h0);
      chk("gated backup", gated, 4'ha);
      // Output supply dips below retention
      settle(5'h00, 5'h00);
      chk("retention", released, 1'h0);
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
